// File: pkg/spi_setup_pkg.sv
// constants shared by the serial configuration register block
package spi_setup_pkg;

	// serial frame layout: read flag, 15-bit address, then data bytes
	localparam int          HDR_BITS        = 16;
	localparam int          ADDR_BITS       = 15;
	localparam int          DATA_BITS       = 8;
	localparam logic [3:0]  HDR_LAST        = 4'hF;
	localparam logic [2:0]  BYTE_LAST       = 3'h7;
	localparam int          RW_POS          = 15;

	// register addresses
	localparam logic [14:0] SETUP_A_ADDR    = 15'h0000;
	localparam logic [14:0] USER_SETUP_ADDR = 15'h0010;
	localparam logic [14:0] ADDR_STEP       = 15'h0001;

	// interface_setup_a fields
	localparam int          SELF_RESET_POS  = 7;
	localparam int          ASCEND_POS      = 5;
	localparam int          OUT_PIN_POS     = 4;
	localparam logic [7:0]  SETUP_A_RESET   = 8'h30;
	localparam logic [7:0]  SETUP_A_WMASK   = 8'h6F;
	localparam logic [7:0]  OUT_PIN_FLAG    = 8'h10;

	// user setup fields
	localparam int          ADDR_FREEZE_POS = 0;
	localparam logic [7:0]  USER_RESET      = 8'h00;
	localparam logic [7:0]  READ_ZERO       = 8'h00;

	// self reset timing
	localparam int          CLK_MHZ         = 40;
	localparam int          SELF_RESET_NS   = 750;
	localparam int          SELF_RESET_MAX  = (SELF_RESET_NS * CLK_MHZ) / 1000;
	// margin covers pin synchroniser latency and the edge detect
	localparam int          SYNC_MARGIN     = 5;
	localparam int          SELF_RESET_HOLD = SELF_RESET_MAX - SYNC_MARGIN;
	localparam logic [4:0]  HOLD_LAST       = 5'(SELF_RESET_HOLD - 1);

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_HDR  = 2'b01,
		ST_DATA = 2'b10
	} link_state_t;

endpackage

// File: logic/pin_filter.sv
// three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/1ps

module pin_filter #(
	parameter int         WIDTH    = 1,
	parameter logic [7:0] INIT_VAL = 8'h00
) (
	input  wire logic             ref_clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] pin_i,
	output logic      [WIDTH-1:0] level_o
);

	// the reset pattern is one byte wide
	if (WIDTH < 1 || WIDTH > 8) begin : g_bad_width
		$error("pin_filter width out of range");
	end

	genvar g;
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic s1_ff;
			logic s2_ff;
			logic s3_ff;
			logic out_ff;
			wire  agree = (s2_ff == s3_ff);

			always_ff @(posedge ref_clk_i) begin
				if (rst_i) begin
					s1_ff  <= INIT_VAL[g];
					s2_ff  <= INIT_VAL[g];
					s3_ff  <= INIT_VAL[g];
					out_ff <= INIT_VAL[g];
				end else begin
					s1_ff  <= pin_i[g];
					s2_ff  <= s1_ff;
					s3_ff  <= s2_ff;
					out_ff <= agree ? s3_ff : out_ff;
				end
			end

			assign level_o[g] = out_ff;
		end
	endgenerate

endmodule

// File: logic/spi_setup_regs.sv
// serial slave with the interface setup and user setup registers
//
// Operation
// - writing one to bit 7 of interface_setup_a resets the whole chip and these registers.
// - the self reset bit returns to zero by itself once the reset has been carried out.
// - the internal reset finishes within 750 ns of the write that requested it.
// - with the direction bit at zero the address falls after each streamed byte.
// - with the direction bit at one, its reset value, the address rises after each byte.
// - bit 4 of interface_setup_a is read only and always reads one.
// - read data leaves only on the dedicated serial output, with no shared data pin mode.
// - interface_setup_a at address 0x0 resets to 0x30.
// - with the address freeze bit at 0x10 set the address stays fixed during streaming.
`timescale 1ns/1ps

module spi_setup_regs (
	input  wire logic ref_clk_i,
	input  wire logic rst_i,
	input  wire logic sclk_i,
	input  wire logic cs_n_i,
	input  wire logic sdi_i,
	output logic      sdo_o,
	output logic      sdo_oe_o,
	output logic      chip_reset_o,
	output logic      ascend_o,
	output logic      addr_freeze_o
);

	// the hold counter is five bits wide, so refuse holds it cannot count
	if (spi_setup_pkg::SELF_RESET_HOLD < 1 || spi_setup_pkg::SELF_RESET_HOLD > 31) begin
		$error("self reset hold count out of range");
	end

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers

	logic [2:0] pins_f;
	logic       sclk_f;
	logic       cs_n_f;
	logic       sdi_f;

	pin_filter #(
		.WIDTH    (3),
		.INIT_VAL (8'h02)
	) u_pins (
		.ref_clk_i (ref_clk_i),
		.rst_i     (rst_i),
		.pin_i     ({sdi_i, cs_n_i, sclk_i}),
		.level_o   (pins_f)
	);

	assign sclk_f = pins_f[0];
	assign cs_n_f = pins_f[1];
	assign sdi_f  = pins_f[2];

	////////////////////////////////////////////////////////////////////////////////
	// self reset sequencer

	logic       busy_ff;
	logic [4:0] hold_cnt_ff;
	logic       self_reset_req;
	logic       regs_rst;
	wire        hold_done = (hold_cnt_ff == spi_setup_pkg::HOLD_LAST);

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			busy_ff     <= 1'b0;
			hold_cnt_ff <= 5'h00;
		end else if (busy_ff) begin
			busy_ff     <= !hold_done;
			hold_cnt_ff <= hold_done ? 5'h00 : hold_cnt_ff + 5'h01;
		end else begin
			busy_ff     <= self_reset_req;
			hold_cnt_ff <= 5'h00;
		end
	end

	assign regs_rst     = rst_i | busy_ff;
	assign chip_reset_o = busy_ff;

	////////////////////////////////////////////////////////////////////////////////
	// registers

	logic [7:0]  setup_a_ff;
	logic [7:0]  user_ff;
	logic        wr_en;
	logic [14:0] wr_addr;
	logic [7:0]  wr_data;

	wire wr_setup_a = wr_en && (wr_addr == spi_setup_pkg::SETUP_A_ADDR);
	wire wr_user    = wr_en && (wr_addr == spi_setup_pkg::USER_SETUP_ADDR);

	assign self_reset_req = wr_setup_a && wr_data[spi_setup_pkg::SELF_RESET_POS];

	always_ff @(posedge ref_clk_i) begin
		if (regs_rst) begin
			setup_a_ff <= spi_setup_pkg::SETUP_A_RESET;
			user_ff    <= spi_setup_pkg::USER_RESET;
		end else begin
			setup_a_ff <= wr_setup_a ? (wr_data & spi_setup_pkg::SETUP_A_WMASK) : setup_a_ff;
			user_ff    <= wr_user ? wr_data : user_ff;
		end
	end

	assign ascend_o      = setup_a_ff[spi_setup_pkg::ASCEND_POS];
	assign addr_freeze_o = user_ff[spi_setup_pkg::ADDR_FREEZE_POS];

	// reset bit reads one only while the reset is pending
	wire [7:0] setup_a_rd = (setup_a_ff & spi_setup_pkg::SETUP_A_WMASK)
	                      | spi_setup_pkg::OUT_PIN_FLAG
	                      | {busy_ff, 7'h00};

	function automatic logic [7:0] read_reg(input logic [14:0] a, input logic [7:0] ra,
	                                        input logic [7:0] ru);
		if (a == spi_setup_pkg::SETUP_A_ADDR) begin
			return ra;
		end else if (a == spi_setup_pkg::USER_SETUP_ADDR) begin
			return ru;
		end
		return spi_setup_pkg::READ_ZERO;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// serial frame engine

	spi_setup_pkg::link_state_t state_ff;
	logic        sclk_d_ff;
	logic [3:0]  hdr_cnt_ff;
	logic [2:0]  bit_cnt_ff;
	logic [15:0] shift_ff;
	logic        rd_ff;
	logic [14:0] addr_ff;
	logic [7:0]  tx_ff;

	wire sclk_rise = sclk_f && !sclk_d_ff;
	wire sclk_fall = !sclk_f && sclk_d_ff;

	wire [15:0] hdr_full  = {shift_ff[14:0], sdi_f};
	wire [14:0] hdr_addr  = hdr_full[spi_setup_pkg::ADDR_BITS-1:0];
	wire        hdr_done  = (state_ff == spi_setup_pkg::ST_HDR) && sclk_rise
	                      && (hdr_cnt_ff == spi_setup_pkg::HDR_LAST);
	wire        byte_done = (state_ff == spi_setup_pkg::ST_DATA) && sclk_rise
	                      && (bit_cnt_ff == spi_setup_pkg::BYTE_LAST);
	wire [7:0]  rx_byte   = {shift_ff[6:0], sdi_f};

	wire [14:0] step_addr = addr_freeze_o ? addr_ff
	                      : ascend_o ? addr_ff + spi_setup_pkg::ADDR_STEP
	                      : addr_ff - spi_setup_pkg::ADDR_STEP;

	assign wr_en   = byte_done && !rd_ff;
	assign wr_addr = addr_ff;
	assign wr_data = rx_byte;

	// the next byte is fetched in the same cycle as the write, so a streamed read-back sees the value from before it
	wire [7:0] next_rd = read_reg(hdr_done ? hdr_addr : step_addr, setup_a_rd, user_ff);
	// shift on falls inside a byte only; the fall right after a load keeps bit 7
	wire       tx_shift = (state_ff == spi_setup_pkg::ST_DATA) && sclk_fall
	                    && (bit_cnt_ff != 3'h0);

	// transactions during the reset hold are ignored
	always_ff @(posedge ref_clk_i) begin
		if (regs_rst || cs_n_f) begin
			state_ff <= spi_setup_pkg::ST_IDLE;
		end else begin
			unique case (state_ff)
				spi_setup_pkg::ST_IDLE: begin
					state_ff <= spi_setup_pkg::ST_HDR;
				end
				spi_setup_pkg::ST_HDR: begin
					state_ff <= hdr_done ? spi_setup_pkg::ST_DATA : spi_setup_pkg::ST_HDR;
				end
				spi_setup_pkg::ST_DATA: begin
					state_ff <= spi_setup_pkg::ST_DATA;
				end
				default: begin
					state_ff <= spi_setup_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			sclk_d_ff <= 1'b0;
		end else begin
			sclk_d_ff <= sclk_f;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (regs_rst || state_ff == spi_setup_pkg::ST_IDLE) begin
			hdr_cnt_ff <= 4'h0;
			bit_cnt_ff <= 3'h0;
			shift_ff   <= 16'h0000;
		end else if (sclk_rise) begin
			hdr_cnt_ff <= (state_ff == spi_setup_pkg::ST_HDR) ? hdr_cnt_ff + 4'h1 : hdr_cnt_ff;
			bit_cnt_ff <= (state_ff == spi_setup_pkg::ST_DATA) ? bit_cnt_ff + 3'h1 : 3'h0;
			shift_ff   <= hdr_full;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (regs_rst) begin
			rd_ff   <= 1'b0;
			addr_ff <= 15'h0000;
		end else if (hdr_done) begin
			rd_ff   <= hdr_full[spi_setup_pkg::RW_POS];
			addr_ff <= hdr_addr;
		end else if (byte_done) begin
			addr_ff <= step_addr;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (regs_rst) begin
			tx_ff <= 8'h00;
		end else if (hdr_done || byte_done) begin
			tx_ff <= next_rd;
		end else if (tx_shift) begin
			tx_ff <= {tx_ff[6:0], 1'b0};
		end
	end

	// reads leave only on the dedicated output
	always_ff @(posedge ref_clk_i) begin
		if (regs_rst) begin
			sdo_o    <= 1'b0;
			sdo_oe_o <= 1'b0;
		end else begin
			sdo_o    <= tx_ff[7];
			sdo_oe_o <= (state_ff == spi_setup_pkg::ST_DATA) && rd_ff && !cs_n_f;
		end
	end

endmodule

// File: testbench/spi_setup_regs_chk.sv
// port assertions for the serial setup register block
`timescale 1ns/1ps
module spi_setup_regs_chk (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic cs_n_i,
	input wire logic sdo_oe_o,
	input wire logic chip_reset_o,
	input wire logic ascend_o,
	input wire logic addr_freeze_o
);
	logic [4:0] held_ff;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i || !chip_reset_o) begin
			held_ff <= 5'h00;
		end else begin
			held_ff <= held_ff + 5'h01;
		end
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	sequence s_idle; cs_n_i [*8]; endsequence
	property p_idle; s_idle |-> !sdo_oe_o; endproperty
	a_idle: assert property (p_idle) else $error("oe while idle");
	property p_drop; $rose(cs_n_i) |-> ##[1:8] !sdo_oe_o; endproperty
	a_drop: assert property (p_drop) else $error("oe stuck");
	property p_len; $fell(chip_reset_o) |-> held_ff == 5'(spi_setup_pkg::SELF_RESET_HOLD); endproperty
	a_len: assert property (p_len) else $error("hold length");
	property p_max; chip_reset_o |-> held_ff < 5'(spi_setup_pkg::SELF_RESET_HOLD); endproperty
	a_max: assert property (p_max) else $error("hold too long");
	property p_after; $fell(chip_reset_o) |-> ascend_o && !addr_freeze_o; endproperty
	a_after: assert property (p_after) else $error("regs kept");
	property p_boot; $fell(rst_i) |-> ascend_o && !addr_freeze_o && !chip_reset_o; endproperty
	a_boot: assert property (p_boot) else $error("reset values");
	property p_asc; $changed(ascend_o) |-> !cs_n_i || chip_reset_o || $past(chip_reset_o); endproperty
	a_asc: assert property (p_asc) else $error("ascend moved");
	property p_frz; $changed(addr_freeze_o) |-> !cs_n_i || chip_reset_o || $past(chip_reset_o); endproperty
	a_frz: assert property (p_frz) else $error("freeze moved");
	property p_quiet; chip_reset_o |-> !sdo_oe_o; endproperty
	a_quiet: assert property (p_quiet) else $error("oe in hold");
endmodule
bind spi_setup_regs spi_setup_regs_chk i_spi_setup_regs_chk (.ref_clk_i, .rst_i, .cs_n_i,
	.sdo_oe_o, .chip_reset_o, .ascend_o, .addr_freeze_o);

// File: testbench/spi_host.sv
// serial host model, mode 0, slow edges for the pin filters
`timescale 1ns/1ps
module spi_host (
	input  wire logic ref_clk_i,
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      sdi_o,
	input  wire logic sdo_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		sdi_o = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk_i);
		#1;
	endtask
	// shifts n bits of b msb first; q collects sdo at each rise
	task automatic frame(input logic [31:0] b, input int n, output logic [31:0] q);
		q = 32'h0000_0000;
		cs_n_o = 1'b0;
		tick(6);
		for (int i = 31; i > 31 - n; i--) begin
			sdi_o = b[i];
			tick(6);
			sclk_o = 1'b1;
			q[i] = sdo_i;
			tick(6);
			sclk_o = 1'b0;
		end
		tick(6);
		cs_n_o = 1'b1;
		// released line must not keep its last level
		sdi_o = ~sdi_o;
		tick(6);
	endtask
endmodule

// File: testbench/test_spi_interface_config_register.sv
// self-checking bench for the serial setup registers
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin err_count++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module test_spi_interface_config_register;
	logic        ref_clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        sclk_i, cs_n_i, sdi_i, sdo_o, sdo_oe_o;
	logic        chip_reset_o, ascend_o, addr_freeze_o;
	logic [31:0] q;
	int          err_count = 0;
	int          n_checks = 0;
	int          oe_cycles = 0;
	always #12.5 ref_clk_i = ~ref_clk_i;
	// counts cycles in which the output pin is driven
	always @(posedge ref_clk_i) begin
		if (sdo_oe_o === 1'b1) begin
			oe_cycles++;
		end
	end
	spi_setup_regs i_spi_setup_regs (.ref_clk_i, .rst_i, .sclk_i, .cs_n_i, .sdi_i, .sdo_o,
		.sdo_oe_o, .chip_reset_o, .ascend_o, .addr_freeze_o);
	spi_host i_spi_host (.ref_clk_i, .sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdi_o(sdi_i),
		.sdo_i(sdo_o));
	////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic t_boot();
		i_spi_host.frame(32'h8000_0000, 32, q);
		`CHK("boot read", 16'h3000, q[15:0])
		`CHK("ascend", 1'b1, ascend_o)
		`CHK("oe read", 1'b1, oe_cycles > 0)
		$display("done boot");
	endtask
	task automatic t_ro();
		int oe0;
		oe0 = oe_cycles;
		i_spi_host.frame(32'h0000_4F00, 24, q);
		`CHK("oe write", 0, oe_cycles - oe0)
		i_spi_host.frame(32'h8000_0000, 24, q);
		`CHK("bit4 kept", 8'h5F, q[15:8])
		`CHK("descend", 1'b0, ascend_o)
		$display("done ro");
	endtask
	task automatic t_desc();
		// second byte lands one below 0x11
		i_spi_host.frame(32'h0011_0001, 32, q);
		`CHK("freeze set", 1'b1, addr_freeze_o)
		i_spi_host.frame(32'h8010_0000, 24, q);
		`CHK("user read", 8'h01, q[15:8])
		$display("done desc");
	endtask
	task automatic t_freeze();
		i_spi_host.frame(32'h8000_0000, 32, q);
		`CHK("frozen read", 16'h5F5F, q[15:0])
		$display("done freeze");
	endtask
	task automatic t_self();
		i_spi_host.frame(32'h0000_8000, 24, q);
		repeat (30) @(posedge ref_clk_i);
		#1;
		`CHK("self clear", 1'b0, chip_reset_o)
		`CHK("freeze gone", 1'b0, addr_freeze_o)
		i_spi_host.frame(32'h8000_0000, 24, q);
		`CHK("after reset", 8'h30, q[15:8])
		$display("done self");
	endtask
	initial begin
		#300us;
		err_count++;
		conclude();
	end
	initial begin
		repeat (12) @(posedge ref_clk_i);
		#1;
		rst_i = 1'b0;
		repeat (2) @(posedge ref_clk_i);
		#1;
		t_boot();
		t_ro();
		t_desc();
		t_freeze();
		t_self();
		conclude();
	end
endmodule
